// [inc/ipc_pkg.sv]
//
// Contract
// - Write during transmit sets write collision flag
// - Byte received while buffer full sets overflow
// - Overflow cleared only by software write
// - Enable bit hands pins to port
// - Clock release zero holds clock low in slave modes
// - Mode 0110: 7-bit slave, no start/stop
// - Mode 1011: firmware master, slave idle
// - Mode 1110: 7-bit slave with start/stop
// - Mode 1111: 10-bit slave with start/stop
// - Mode 1001: address location reaches mask
package ipc_pkg;

	// ========================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_BUFFER  = 8'h04;
	localparam logic [7:0] ADDR_SLAVE   = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0C;
	localparam logic [7:0] ADDR_MASTER  = 8'h10;

	// ========================================
	// Control field positions and reset values
	localparam int WRITE_COLLISION_FLAG_BIT   = 7;
	localparam int ROV_BIT    = 6;
	localparam int EN_BIT     = 5;
	localparam int CKR_BIT    = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET    = 8'hFF;
	localparam logic [7:0] SLAVE_RESET   = 8'h00;
	localparam logic [9:0] ADDR10_RESET  = 10'h000;

	// ========================================
	// Mode codes
	localparam logic [3:0] MODE_S7      = 4'h6;
	localparam logic [3:0] MODE_MASK    = 4'h9;
	localparam logic [3:0] MODE_MASTER  = 4'hB;
	localparam logic [3:0] MODE_S7_SP   = 4'hE;
	localparam logic [3:0] MODE_S10_SP  = 4'hF;

	// ========================================
	// Bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam int BYTE_BITS = 8;

	// Pin state carried together
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} ipc_pins_type;

	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic addr_match;
		logic busy;
	} ipc_status_type;

endpackage

// [src/ipc_shift.sv]
// ========================================
// Byte shifter: holds the received or outgoing byte in a register
module ipc_shift (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       shift_in,
	input  wire logic       bit_in,
	output logic      [7:0] data,
	output logic            msb
);
	// Shift register, MSB first as on the wire
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data <= 8'h00;
		end else if (load) begin
			data <= load_data;
		end else if (shift_in) begin
			data <= {data[6:0], bit_in};
		end
	end

	assign msb = data[7];
endmodule

// [src/ipc_port.sv]
// ========================================
// Two-wire serial port control, AHB-Lite register slave
//
// The AHB-Lite register port and the register addresses were left to the implementer.
module ipc_port (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             pins_owned,
	output logic             start_stop_irq
);

	// ========================================
	// Registers
	logic [7:0]  control;
	logic [7:0]  slave_addr;
	logic [7:0]  addr_mask;
	logic [7:0]  rx_hold;
	logic        rx_full;
	logic [7:0]  master_ctl;
	ipc_pkg::ipc_status_type status;
	ipc_pkg::ipc_pins_type   pins;

	logic [3:0] mode;
	assign mode = control[3:0];

	// ========================================
	// Pin synchronisers, two flops before any logic
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_d;
	logic       sda_d;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_s     = scl_sync[1];
	assign sda_s     = sda_sync[1];
	assign scl_rise  = scl_s && !scl_d;
	assign scl_fall  = !scl_s && scl_d;
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

	// ========================================
	// Mode decode helpers
	function automatic logic is_slave(input logic [3:0] m);
		is_slave = (m == ipc_pkg::MODE_S7) ||
			(m == ipc_pkg::MODE_S7_SP) ||
			(m == ipc_pkg::MODE_S10_SP);
	endfunction

	function automatic logic is_active(input logic [3:0] m);
		// Reserved or unlisted codes stay off the bus
		is_active = is_slave(m) || (m == ipc_pkg::MODE_MASTER);
	endfunction

	// ========================================
	// Slave transfer engine
	typedef enum logic [2:0] {
		IPC_IDLE, IPC_ADDR, IPC_ADDR2, IPC_ACK, IPC_DATA, IPC_DACK
	} ipc_state_type;
	ipc_state_type state;
	logic [3:0] bit_cnt;
	logic       xmit;
	logic       byte_done;
	logic       ack_drive;
	logic [7:0] sh_data;
	logic       sh_msb;
	logic       sh_load;
	logic [7:0] tx_data;
	logic       tx_pending;
	logic       slave_on;
	assign slave_on  = control[ipc_pkg::EN_BIT] && is_slave(mode);
	assign byte_done = scl_rise && (bit_cnt == 4'h7);
	assign sh_load   = (state == IPC_DACK) && scl_fall && xmit;

	ipc_shift u_shift (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.load      (sh_load),
		.load_data (tx_data),
		.shift_in  (scl_rise && state != IPC_ACK && state != IPC_DACK),
		.bit_in    (sda_s),
		.data      (sh_data),
		.msb       (sh_msb)
	);

	// Address compare under mask
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] s, input logic [7:0] m);
		addr_hit = ((a[7:1] ^ s[7:1]) & m[7:1]) == 7'h00;
	endfunction

	// Slave state machine; start aborts any transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state   <= IPC_IDLE;
			bit_cnt <= 4'h0;
			xmit    <= 1'b0;
		end else if (!slave_on || stop_det) begin
			state   <= IPC_IDLE;
			bit_cnt <= 4'h0;
		end else if (start_det) begin
			state   <= IPC_ADDR;
			bit_cnt <= 4'h0;
			xmit    <= 1'b0;
		end else begin
			case (state)
			IPC_IDLE: begin
			end
			IPC_ADDR, IPC_ADDR2, IPC_DATA: begin
				if (scl_rise) begin
					bit_cnt <= bit_cnt + 4'h1;
				end
				if (byte_done) begin
					bit_cnt <= 4'h0;
					if (state == IPC_DATA) begin
						state <= IPC_DACK;
					// 10-bit header is 11110xx then second byte
					end else if (state == IPC_ADDR &&
						mode == ipc_pkg::MODE_S10_SP) begin
						state <= (sh_data[6:2] == 5'h1E)
							? IPC_ADDR2 : IPC_IDLE;
					end else if (addr_hit({sh_data[6:0], sda_s},
						slave_addr, addr_mask)) begin
						state <= IPC_ACK;
						xmit  <= sda_s;
					end else begin
						state <= IPC_IDLE;
					end
				end
			end
			IPC_ACK, IPC_DACK: begin
				// First fall opens the ninth bit, second ends it
				if (scl_fall && bit_cnt[0]) begin
					state   <= IPC_DATA;
					bit_cnt <= 4'h0;
				end else if (scl_fall) begin
					bit_cnt <= 4'h1;
				end
			end
			default: state <= IPC_IDLE;
			endcase
		end
	end

	// ========================================
	// Receive hold and overflow
	logic rx_take;
	assign rx_take = (state == IPC_DATA) && byte_done && !xmit;
	logic buf_rd;
	logic buf_wr;
	logic ctl_wr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_hold <= 8'h00;
			rx_full <= 1'b0;
		end else if (rx_take) begin
			rx_hold <= {sh_data[6:0], sda_s};
			rx_full <= 1'b1;
		end else if (buf_rd) begin
			rx_full <= 1'b0;
		end
	end

	// Transmit holding byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_data    <= 8'h00;
			tx_pending <= 1'b0;
		end else if (buf_wr && !tx_pending) begin
			tx_data    <= hwdata[7:0];
			tx_pending <= 1'b1;
		end else if (sh_load) begin
			tx_pending <= 1'b0;
		end
	end

	// ========================================
	// AHB-Lite address phase capture
	logic       dp_valid;
	logic       dp_write;
	logic [7:0] dp_addr;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (hready) begin
			dp_valid <= hsel && htrans == ipc_pkg::HTRANS_NONSEQ;
			dp_write <= hwrite;
			dp_addr  <= haddr;
		end
	end

	logic alias_mask;
	assign alias_mask = (mode == ipc_pkg::MODE_MASK);
	assign ctl_wr = dp_valid && dp_write && dp_addr == ipc_pkg::ADDR_CONTROL;
	assign buf_wr = dp_valid && dp_write && dp_addr == ipc_pkg::ADDR_BUFFER;
	assign buf_rd = dp_valid && !dp_write &&
		dp_addr == ipc_pkg::ADDR_BUFFER;

	// Control register; hardware set beats software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control <= ipc_pkg::CONTROL_RESET;
		end else begin
			if (ctl_wr) begin
				control <= hwdata[7:0];
			end
			if (buf_wr && (tx_pending || state == IPC_DATA && xmit)) begin
				control[ipc_pkg::WRITE_COLLISION_FLAG_BIT] <= 1'b1;
			end
			if (rx_take && rx_full) begin
				control[ipc_pkg::ROV_BIT] <= 1'b1;
			end
		end
	end

	// Address, mask and master registers; mask aliasing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slave_addr <= ipc_pkg::SLAVE_RESET;
			addr_mask  <= ipc_pkg::MASK_RESET;
			master_ctl <= 8'h00;
		end else if (dp_valid && dp_write) begin
			if (dp_addr == ipc_pkg::ADDR_SLAVE && alias_mask) begin
				addr_mask <= hwdata[7:0];
			end else if (dp_addr == ipc_pkg::ADDR_SLAVE) begin
				slave_addr <= hwdata[7:0];
			end else if (dp_addr == ipc_pkg::ADDR_MASTER) begin
				master_ctl <= hwdata[7:0];
			end
		end
	end

	// Status and start/stop event flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= '0;
		end else begin
			status.busy       <= state != IPC_IDLE;
			status.addr_match <= state == IPC_ACK;
			if (start_det) begin
				status.start_seen <= 1'b1;
			end else if (dp_valid && dp_write &&
				dp_addr == ipc_pkg::ADDR_STATUS) begin
				status.start_seen <= 1'b0;
			end
			if (stop_det) begin
				status.stop_seen <= 1'b1;
			end else if (dp_valid && dp_write &&
				dp_addr == ipc_pkg::ADDR_STATUS) begin
				status.stop_seen <= 1'b0;
			end
		end
	end

	// ========================================
	// Read data register, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans == ipc_pkg::HTRANS_NONSEQ
			&& !hwrite) begin
			if (haddr == ipc_pkg::ADDR_CONTROL) begin
				hrdata <= {24'h000000, control};
			end else if (haddr == ipc_pkg::ADDR_BUFFER) begin
				hrdata <= {24'h000000, rx_hold};
			end else if (haddr == ipc_pkg::ADDR_SLAVE && alias_mask) begin
				hrdata <= {24'h000000, addr_mask};
			end else if (haddr == ipc_pkg::ADDR_SLAVE) begin
				hrdata <= {24'h000000, slave_addr};
			end else if (haddr == ipc_pkg::ADDR_STATUS) begin
				hrdata <= {28'h0000000, status};
			end else if (haddr == ipc_pkg::ADDR_MASTER) begin
				hrdata <= {24'h000000, master_ctl};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ========================================
	// Pin drive; open drain, only low is driven
	logic en_ok;
	assign en_ok     = control[ipc_pkg::EN_BIT] && is_active(mode);
	// Acknowledge pull is held through the ninth clock high; transmit bits follow sh_msb, which shifts on scl_rise
	assign ack_drive = (state == IPC_ACK && bit_cnt[0]) ||
		(state == IPC_DACK && bit_cnt[0] && !xmit) ||
		(state == IPC_DATA && xmit && !sh_msb);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins       <= '0;
			pins_owned <= 1'b0;
		end else begin
			pins_owned   <= control[ipc_pkg::EN_BIT];
			pins.scl_o   <= 1'b0;
			pins.sda_o   <= 1'b0;
			if (mode == ipc_pkg::MODE_MASTER) begin
				// Firmware drives lines: bit0 pulls SCL, bit1 SDA
				pins.scl_oe <= en_ok && master_ctl[0];
				pins.sda_oe <= en_ok && master_ctl[1];
			end else begin
				pins.scl_oe <= en_ok &&
					!control[ipc_pkg::CKR_BIT] && !scl_s;
				pins.sda_oe <= en_ok && ack_drive;
			end
		end
	end
	assign scl_o  = pins.scl_o;
	assign scl_oe = pins.scl_oe;
	assign sda_o  = pins.sda_o;
	assign sda_oe = pins.sda_oe;

	// Interrupt pulse only in start/stop modes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_stop_irq <= 1'b0;
		end else begin
			start_stop_irq <= control[ipc_pkg::EN_BIT] &&
				(mode == ipc_pkg::MODE_S7_SP ||
				mode == ipc_pkg::MODE_S10_SP) &&
				(start_det || stop_det);
		end
	end
endmodule

// [bench/ipc_port_monitor.sv]
// ========================================
// Checker on the port pins and the bus
module ipc_port_monitor (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        pins_owned,
	input wire logic        start_stop_irq
);
	logic       wr_q;
	logic [7:0] wa_q;
	logic [7:0] ctl;
	logic [1:0] mst;
	logic [1:0] age;
	logic       calm;
	logic       dw;

	// Write address phase kept for its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'h0;
			wa_q <= 8'h00;
		end else if (hready) begin
			wr_q <= hsel && hwrite && htrans[1];
			wa_q <= haddr;
		end
	end
	assign dw = wr_q && hready;
	// Shadow settings; age gives registered outputs time to follow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl <= ipc_pkg::CONTROL_RESET;
			mst <= 2'h0;
			age <= 2'h0;
		end else if (dw && wa_q == ipc_pkg::ADDR_CONTROL) begin
			ctl <= hwdata[7:0];
			age <= 2'h0;
		end else if (dw && wa_q == ipc_pkg::ADDR_MASTER) begin
			mst <= hwdata[1:0];
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	assign calm = age == 2'h3;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_enable_pins: assert property (
		calm |-> pins_owned == ctl[5]) else $error("ownership wrong");
	a_pins_free: assert property (
		calm && !pins_owned |-> !scl_oe && !sda_oe)
		else $error("line pulled while disabled");
	a_open_drain: assert property (
		!scl_o && !sda_o) else $error("line driven high");
	a_clock_release: assert property (
		calm && ctl[5:4] == 2'h3 && ctl[3:0] != 4'hB |-> !scl_oe)
		else $error("clock held though released");
	a_reserved_quiet: assert property (
		calm && !(ctl[3:0] inside {4'h6, 4'h9, 4'hB, 4'hE, 4'hF})
		|-> !scl_oe && !sda_oe) else $error("reserved mode drives");
	a_irq_modes: assert property (
		start_stop_irq |-> ctl[5] && ctl[3:0] inside {4'hE, 4'hF})
		else $error("event pulse in wrong mode");
	a_irq_pulse: assert property (
		start_stop_irq |=> !start_stop_irq) else $error("pulse too long");
	a_master_drive: assert property (
		calm && ctl[5:4] == 2'h3 && ctl[3:0] == 4'hB
		|-> scl_oe == mst[0] && sda_oe == mst[1])
		else $error("master lines differ");
	a_bus_okay: assert property (
		hreadyout && !hresp) else $error("bus not ready or error");
	c_event: cover property (start_stop_irq);
	c_stretch: cover property (pins_owned && scl_oe && !ctl[4]);
	c_master: cover property (calm && ctl[3:0] == 4'hB && sda_oe);
endmodule

bind ipc_port ipc_port_monitor mon (.*);

// [bench/ipc_i2c_master.sv]
// ========================================
// Far-side bus master, pull-ups on both lines
module ipc_i2c_master (
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic     scl_i,
	output logic     sda_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_d = 1'h1;
	logic sda_d = 1'h1;
	// Open drain: a released line floats high
	assign scl_i = scl_d & ~scl_oe;
	assign sda_i = sda_d & ~sda_oe;
	// Release clock, wait out a bounded stretch
	task hi;
		int n;
		n = 0;
		scl_d = 1'h1;
		while (!scl_i && n < 400) begin
			#25;
			n++;
		end
		#100;
	endtask
	// Clock stands high between frames
	task start;
		#100 sda_d = 1'h0;
		#100 scl_d = 1'h0;
	endtask
	task stop;
		#100 sda_d = 1'h0;
		#100 hi;
		sda_d = 1'h1;
		#200;
	endtask
	// Eight bits first to last, ninth released for acknowledge
	// Late data change leaves room for the slave's synced release
	task put(input logic [7:0] b, output logic a);
		for (int i = 8; i >= 0; i--) begin
			#150 sda_d = i > 0 ? b[i - 1] : 1'h1;
			#150 hi;
			if (i == 0) a = !sda_i;
			scl_d = 1'h0;
		end
	endtask
endmodule

// [bench/i2c_port_control_tb.sv]
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
// ========================================
// Bench top
module i2c_port_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic        hwrite = 1'h0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, r;
	logic        hreadyout, hresp, scl_i, sda_i, scl_o, scl_oe;
	logic        sda_o, sda_oe, pins_owned, start_stop_irq, ack;
	int          err_total = 0, checked = 0, irqs = 0;

	always #25 hclk = ~hclk;
	// Count start and stop pulses
	always @(posedge hclk) if (start_stop_irq === 1'h1) irqs++;
	ipc_port dut (.*, .hready(hreadyout), .hsize(3'h2));
	ipc_i2c_master m (.*);

	task summarize;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bounded wait for ready at a rising edge
	task rdy;
		int n;
		n = 0;
		do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 99);
		if (n >= 99) begin
			err_total++;
			summarize;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= ipc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'h1, a, {24'h0, d});
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'h0, a, 32'h0);
		`CHK(r, {24'h0, e})
	endtask
	task ctl(input logic [7:0] d);
		wr(ipc_pkg::ADDR_CONTROL, d);
		repeat (4) @(posedge hclk);
	endtask
	task flag(input int b, input logic e);
		bus(1'h0, ipc_pkg::ADDR_CONTROL, 32'h0);
		`CHK(r[b], e)
	endtask
	// One frame, address byte only
	task frame(input logic [7:0] a, input logic e);
		m.start;
		m.put(a, ack);
		m.stop;
		`CHK(ack, e)
	endtask
	// ========================================
	// Scenarios
	task t_regs;
		rd(ipc_pkg::ADDR_CONTROL, 8'h00);
		wr(8'h14, 8'hAA);
		rd(8'h14, 8'h00);
		ctl(8'h29);
		rd(ipc_pkg::ADDR_SLAVE, 8'hFF);
		wr(ipc_pkg::ADDR_SLAVE, 8'hFE);
		ctl(8'h36);
		rd(ipc_pkg::ADDR_SLAVE, 8'h00);
		wr(ipc_pkg::ADDR_SLAVE, 8'h50);
		ctl(8'h29);
		rd(ipc_pkg::ADDR_SLAVE, 8'hFE);
		ctl(8'h36);
		rd(ipc_pkg::ADDR_CONTROL, 8'h36);
		`CHK(pins_owned, 1'h1)
		$display("regs done");
	endtask
	// Matched frame with two unread data bytes, then a stranger
	task t_slave(input logic [3:0] md, input int n);
		bus(1'h0, ipc_pkg::ADDR_BUFFER, 32'h0);
		ctl({4'h3, md});
		irqs = 0;
		m.start;
		m.put(8'h50, ack);
		`CHK(ack, 1'h1)
		m.put(8'h11, ack);
		m.put(8'h22, ack);
		m.stop;
		repeat (8) @(posedge hclk);
		`CHK(irqs, n)
		flag(6, 1'h1);
		repeat (20) @(posedge hclk);
		flag(6, 1'h1);
		ctl({4'h3, md});
		flag(6, 1'h0);
		frame(8'h52, 1'h0);
		$display("slave done");
	endtask
	task t_ten;
		ctl(8'h3F);
		irqs = 0;
		frame(8'h11, 1'h0);
		repeat (8) @(posedge hclk);
		`CHK(irqs, 2)
		$display("ten done");
	endtask
	task t_stretch;
		bus(1'h0, ipc_pkg::ADDR_BUFFER, 32'h0);
		ctl(8'h26);
		m.start;
		m.put(8'h50, ack);
		repeat (6) @(posedge hclk);
		`CHK(scl_oe, 1'h1)
		ctl(8'h36);
		`CHK(scl_oe, 1'h0)
		m.stop;
		$display("stretch done");
	endtask
	task t_master;
		ctl(8'h3B);
		wr(ipc_pkg::ADDR_MASTER, 8'h03);
		repeat (4) @(posedge hclk);
		`CHK({scl_oe, sda_oe}, 2'h3)
		wr(ipc_pkg::ADDR_MASTER, 8'h00);
		repeat (4) @(posedge hclk);
		`CHK({scl_oe, sda_oe}, 2'h0)
		frame(8'h50, 1'h0);
		$display("master done");
	endtask
	// Reserved and unlisted codes, clock hold requested
	task t_reserved;
		logic [3:0] codes[6];
		codes = '{4'h0, 4'h7, 4'h8, 4'hA, 4'hC, 4'hD};
		foreach (codes[i]) begin
			ctl({4'h2, codes[i]});
			`CHK({scl_oe, sda_oe}, 2'h0)
			frame(8'h50, 1'h0);
		end
		$display("reserved done");
	endtask
	task t_collide;
		ctl(8'h36);
		wr(ipc_pkg::ADDR_BUFFER, 8'hA5);
		wr(ipc_pkg::ADDR_BUFFER, 8'h5A);
		flag(7, 1'h1);
		repeat (20) @(posedge hclk);
		flag(7, 1'h1);
		ctl(8'h36);
		rd(ipc_pkg::ADDR_CONTROL, 8'h36);
		ctl(8'h06);
		`CHK(pins_owned, 1'h0)
		$display("collide done");
	endtask

	// Main sequence after a held reset
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_regs;
		t_slave(4'h6, 0);
		t_slave(4'hE, 2);
		t_ten;
		t_stretch;
		t_master;
		t_reserved;
		t_collide;
		summarize;
	end
endmodule
